// [pin_sync.sv]
// three-stage synchroniser; output changes when stages two and three agree
// assumes an asynchronous input pin
`timescale 1ns/10ps
module pin_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin
	input wire logic din,
	output logic dout_ff
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			dout_ff <= 1'b1;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				dout_ff <= s3_ff;
		end
	end
endmodule // pin_sync

// [reset_interrupt_vectoring_tb_top.sv]
// self-checking bench for the reset and interrupt vectoring unit
// assumes zero-wait ahb-lite slave and the partner model beside it
`timescale 1ns/10ps
module reset_interrupt_vectoring_tb_top;
	import vec_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic opt = 1'b0;
	logic kick = 1'b0;
	logic pull_low = 1'b0;
	logic [31:0] hrdata;
	logic hreadyout, hready, hresp, wdt_overflow, reset_pin;
	logic port0_bit4_input, wake_up, sys_reset, irq;
	logic [13:0] program_counter;
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	logic [7:0] a1, a2, f;
	logic [31:0] r;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	reset_irq_vec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_reset_option(opt),
		.reset_pin(reset_pin), .wdt_overflow(wdt_overflow),
		.port0_bit4_input(port0_bit4_input), .wake_up(wake_up),
		.program_counter(program_counter), .sys_reset(sys_reset),
		.irq(irq));
	vec_partner far (.hclk(hclk), .kick(kick), .pull_low(pull_low),
		.wdt_overflow(wdt_overflow), .reset_pin(reset_pin));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] cause(input int k);
		return (k == 2) ? 8'hc0 : 8'h00;
	endfunction
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			mismatches++;
		end
	endtask
	// bounded wait for hready sampled high at a rising edge
	task automatic edge_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			mismatches++;
			close_out();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rv);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		edge_ready();
		rv = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rv;
		xfer(1'b1, a, d, rv);
		repeat (3) @(posedge hclk);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] rv;
		xfer(1'b0, a, 32'h0, rv);
		chk(nm, rv, e);
	endtask
	task automatic pc_chk(input logic [13:0] e);
		chk("pc", {18'h0, program_counter}, {18'h0, e});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n = $urandom(15);
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		pc_chk(reset_vector);
		rd_chk("flag", off_flag, 32'h80);
		rd_chk("unmapped", 8'h1c, 32'h0);
		a1 = 8'($urandom);
		a2 = 8'($urandom);
		f = 8'($urandom) & 8'h3f;
		wr(off_acc, {24'h0, a1});
		wr(off_flag, {24'h0, f});
		wr(off_ctrl, 32'h1 << cmd_save);
		wr(off_acc, {24'h0, a2});
		wr(off_ctrl, 32'h1 << cmd_save);
		wr(off_acc, {24'h0, ~a2});
		wr(off_flag, 32'h0);
		wr(off_ctrl, 32'h1 << cmd_restore);
		rd_chk("acc", off_acc, {24'h0, a2});
		rd_chk("flag", off_flag, {24'h0, f | 8'h80});
		n = $urandom_range(6, 1);
		repeat (n) wr(off_ctrl, 32'h1 << cmd_step);
		for (int i = 0; i < 9; i++) begin
			wr(off_ctrl, 32'h1 << cmd_irq);
			if (i == 0) pc_chk(irq_vector);
		end
		rd_chk("depth", off_depth, 32'h8);
		xfer(1'b0, off_status, 32'h0, r);
		chk("ovf", {30'h0, r[ev_ovf], r[ev_irq]}, 32'h3);
		for (int i = 0; i < 8; i++) wr(off_ctrl, 32'h1 << cmd_interrupt_return_instruction);
		pc_chk(14'(n));
		rd_chk("pcreg", off_pc, {18'h0, 14'(n)});
		rd_chk("depth", off_depth, 32'h0);
		wr(off_ctrl, 32'h1 << cmd_interrupt_return_instruction);
		xfer(1'b0, off_status, 32'h0, r);
		chk("unf", {31'h0, r[ev_unf]}, 32'h1);
		wr(off_mask, 32'h1 << ev_irq);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(off_status, 32'h1 << ev_irq);
		chk("irq", {31'h0, irq}, 32'h0);
		// pin as plain input: going low must wake, not reset
		pull_low <= 1'b1;
		for (int k = 0; k < 10 && wake_up !== 1'b1; k++) @(posedge hclk);
		chk("wake", {31'h0, wake_up}, 32'h1);
		repeat (4) @(posedge hclk);
		pc_chk(14'(n));
		chk("p04", {31'h0, port0_bit4_input}, 32'h0);
		pull_low <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			wr(off_acc, 32'h5a);
			wr(off_ctrl, 32'h1 << cmd_step);
			if (k == 0) begin
				kick <= 1'b1;
				@(posedge hclk);
				kick <= 1'b0;
			end else if (k == 1) begin
				wr(off_ctrl, 32'h1 << cmd_wdt);
			end else begin
				opt <= 1'b1;
				pull_low <= 1'b1;
				repeat (10) @(posedge hclk);
				chk("sysrst", {31'h0, sys_reset}, 32'h1);
				chk("p04", {31'h0, port0_bit4_input}, 32'h1);
				pull_low <= 1'b0;
			end
			repeat (10) @(posedge hclk);
			pc_chk(reset_vector);
			rd_chk("acc", off_acc, 32'h0);
			rd_chk("cause", off_flag, {24'h0, cause(k)});
		end
		// power-on reset in mid-run must bring the causes back to 10
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		pc_chk(reset_vector);
		rd_chk("por", off_flag, 32'h80);
		rd_chk("pordepth", off_depth, 32'h0);
		close_out();
	end
endmodule // reset_interrupt_vectoring_tb_top

// [reset_irq_vec.sv]
// reset-cause recording, program counter vectoring and context buffer
// assumes hresetn is the power-on reset; the pin reset arrives on a port pin
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module reset_irq_vec import vec_pkg::*; (
	// clock and power-on reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pins and options
	input wire logic ext_reset_option,
	input wire logic reset_pin,
	input wire logic wdt_overflow,
	output logic port0_bit4_input,
	output logic wake_up,
	// core view
	output logic [13:0] program_counter,
	output logic sys_reset,
	output logic irq
);
	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	logic pin_s;
	pin_sync u_pin (
		.hclk(hclk),
		.hresetn(hresetn),
		.din(reset_pin),
		.dout_ff(pin_s)
	);
	logic pin_d_ff;
	logic opt_ff;
	wire logic pin_reset = opt_ff && !pin_s;
	wire logic pin_edge = !opt_ff && (pin_s != pin_d_ff);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic wr_ff;
	logic rd_ff;
	logic [7:0] a_ff;
	wire logic take = hsel && hready && htrans[1];
	wire logic wr_ctrl = wr_ff && (a_ff == off_ctrl);
	wire logic wr_flag = wr_ff && (a_ff == off_flag);
	wire logic wr_acc = wr_ff && (a_ff == off_acc);
	wire logic wr_stat = wr_ff && (a_ff == off_status);
	wire logic wr_mask = wr_ff && (a_ff == off_mask);
	wire logic [5:0] cmd = wr_ctrl ? hwdata[5:0] : 6'h00;

	// ----------------------------------------------------------------
	// core state
	// ----------------------------------------------------------------
	logic [13:0] pc_ff;
	logic [7:0] flag_ff;
	logic [7:0] acc_ff;
	logic [7:0] sv_acc_ff;
	logic [7:0] sv_flag_ff;
	logic to_ff;
	logic pd_ff;
	logic wdt_rst;
	logic [ev_w-1:0] stat_ff;
	logic [ev_w-1:0] mask_ff;
	logic rst_ff;
	logic [13:0] top;
	logic [3:0] depth;
	logic ovf;
	logic unf;
	wire logic any_rst = wdt_rst || pin_reset;
	wire logic do_irq = cmd[cmd_irq] && !any_rst;
	wire logic do_interrupt_return_instruction = cmd[cmd_interrupt_return_instruction] && !cmd[cmd_irq] && !any_rst;
	assign wdt_rst = wdt_overflow || cmd[cmd_wdt];

	ret_stack u_stack (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(any_rst),
		.push(do_irq),
		.pop(do_interrupt_return_instruction),
		.wdata(pc_ff),
		.top_ff(top),
		.count_ff(depth),
		.overflow(ovf),
		.underflow(unf)
	);

	// the popped word lands one cycle later; pc follows it then
	logic interrupt_return_instruction_d_ff;
	wire logic [13:0] nxt_pc = any_rst ? reset_vector :
		do_irq ? irq_vector :
		interrupt_return_instruction_d_ff ? top :
		cmd[cmd_step] ? 14'(pc_ff + 14'h1) : pc_ff;
	wire logic [7:0] keep_cause = sv_flag_ff & ~cause_mask;
	wire logic [7:0] nxt_flag = cmd[cmd_restore] ?
		keep_cause : (wr_flag ? (hwdata[7:0] & ~cause_mask) : flag_ff);
	wire logic [7:0] flag_view = (flag_ff & ~cause_mask) |
		{to_ff, pd_ff, 6'h00};
	wire logic [ev_w-1:0] ev = {pin_edge, unf, ovf, do_irq, any_rst};
	wire logic [ev_w-1:0] nxt_stat = ev |
		(stat_ff & ~(wr_stat ? hwdata[ev_w-1:0] : '0));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			a_ff <= 8'h00;
		end else begin
			wr_ff <= take && hwrite;
			rd_ff <= take && !hwrite;
			a_ff <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b0;
		end else if (pin_reset) begin
			to_ff <= 1'b1;
			pd_ff <= 1'b1;
		end else if (wdt_rst) begin
			to_ff <= 1'b0;
			pd_ff <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_ff <= reset_vector;
			flag_ff <= flag_reset_val;
			acc_ff <= acc_reset_val;
			interrupt_return_instruction_d_ff <= 1'b0;
		end else if (any_rst) begin
			pc_ff <= reset_vector;
			flag_ff <= flag_reset_val;
			acc_ff <= acc_reset_val;
			interrupt_return_instruction_d_ff <= 1'b0;
		end else begin
			pc_ff <= nxt_pc;
			flag_ff <= nxt_flag;
			acc_ff <= cmd[cmd_restore] ? sv_acc_ff :
				(wr_acc ? hwdata[7:0] : acc_ff);
			interrupt_return_instruction_d_ff <= do_interrupt_return_instruction;
		end
	end

	// single buffer: each save simply overwrites the last
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sv_acc_ff <= acc_reset_val;
			sv_flag_ff <= flag_reset_val;
		end else if (cmd[cmd_save]) begin
			sv_acc_ff <= acc_ff;
			sv_flag_ff <= flag_ff & ~cause_mask;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= '0;
			mask_ff <= '0;
			opt_ff <= 1'b0;
			pin_d_ff <= 1'b1;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= wr_mask ? hwdata[ev_w-1:0] : mask_ff;
			opt_ff <= ext_reset_option;
			pin_d_ff <= pin_s;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	wire logic [31:0] rd_mux =
		(haddr == off_pc) ? {18'h0, pc_ff} :
		(haddr == off_flag) ? {24'h0, flag_view} :
		(haddr == off_acc) ? {24'h0, acc_ff} :
		(haddr == off_status) ? {27'h0, stat_ff} :
		(haddr == off_mask) ? {27'h0, mask_ff} :
		(haddr == off_depth) ? {28'h0, depth} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			irq <= 1'b0;
			rst_ff <= 1'b1;
			port0_bit4_input <= 1'b1;
			wake_up <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (take && !hwrite) ? rd_mux : 32'h0;
			irq <= |(nxt_stat & (wr_mask ? hwdata[ev_w-1:0] : mask_ff));
			rst_ff <= any_rst;
			port0_bit4_input <= opt_ff ? 1'b1 : pin_s;
			wake_up <= pin_edge;
			// zero-wait slave: ready and okay held in flops, never toggled
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign program_counter = pc_ff;
	assign sys_reset = rst_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// reset and cause flags
	property p_rst_pc;
		any_rst |=> (pc_ff == 14'h0000);
	endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("pc not zero");

	property p_rst_regs;
		any_rst |=> (acc_ff == acc_reset_val) &&
			(flag_ff == flag_reset_val) && (depth == 4'h0);
	endproperty
	a_rst_regs: assert property (p_rst_regs) else $error("defaults");

	property p_rst_out;
		any_rst |=> sys_reset;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("sys reset");

	property p_rst_stat;
		any_rst |=> stat_ff[ev_reset];
	endproperty
	a_rst_stat: assert property (p_rst_stat) else $error("reset ev");

	property p_wdt_cause;
		(wdt_rst && !pin_reset) |=> (!to_ff && !pd_ff);
	endproperty
	a_wdt_cause: assert property (p_wdt_cause) else $error("wdt cause");

	property p_pin_cause;
		pin_reset |=> (to_ff && pd_ff);
	endproperty
	a_pin_cause: assert property (p_pin_cause) else $error("pin cause");

	property p_pinrst;
		opt_ff && !pin_s |=> sys_reset;
	endproperty
	a_pinrst: assert property (p_pinrst) else $error("pin reset");

	// read data is taken from the view one edge before it shows
	property p_view;
		rd_ff && (a_ff == off_flag) |->
			(hrdata[7:6] == $past({to_ff, pd_ff}));
	endproperty
	a_view: assert property (p_view) else $error("flag view");

	// stack and vectoring
	property p_irq_vec;
		do_irq |=> (pc_ff == 14'h0008) && (depth != 4'h0);
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("irq vector");

	property p_irq_stat;
		do_irq |=> stat_ff[ev_irq];
	endproperty
	a_irq_stat: assert property (p_irq_stat) else $error("irq event");

	property p_irq_out;
		irq == |(stat_ff & mask_ff);
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq level");

	property p_push_cnt;
		do_irq && (depth < 4'h8) |=> (depth == $past(depth) + 4'h1);
	endproperty
	a_push_cnt: assert property (p_push_cnt) else $error("push");

	property p_depth;
		(depth == 4'h8) && do_irq |=> (depth == 4'h8) && stat_ff[ev_ovf];
	endproperty
	a_depth: assert property (p_depth) else $error("stack depth");

	property p_pop_cnt;
		do_interrupt_return_instruction && (depth != 4'h0) |=> (depth == $past(depth) - 4'h1);
	endproperty
	a_pop_cnt: assert property (p_pop_cnt) else $error("pop");

	property p_interrupt_return_instruction;
		do_interrupt_return_instruction && (depth != 4'h0) |=> ##1 (pc_ff == $past(top, 1));
	endproperty
	a_interrupt_return_instruction: assert property (p_interrupt_return_instruction) else $error("interrupt_return_instruction pc");

	property p_interrupt_return_instruction_empty;
		do_interrupt_return_instruction && (depth == 4'h0) |=> stat_ff[ev_unf];
	endproperty
	a_interrupt_return_instruction_empty: assert property (p_interrupt_return_instruction_empty) else $error("unf");

	// context buffer
	property p_save;
		cmd[cmd_save] |=> (sv_acc_ff == $past(acc_ff)) &&
			(sv_flag_ff == ($past(flag_ff) & ~cause_mask));
	endproperty
	a_save: assert property (p_save) else $error("save");

	property p_restore;
		cmd[cmd_restore] && !any_rst |=> (acc_ff == $past(sv_acc_ff)) &&
			(flag_ff == $past(sv_flag_ff));
	endproperty
	a_restore: assert property (p_restore) else $error("restore");

	// pin and bus
	property p_wake;
		pin_edge |=> wake_up && stat_ff[ev_wake];
	endproperty
	a_wake: assert property (p_wake) else $error("wake");

	property p_p04;
		opt_ff |=> port0_bit4_input;
	endproperty
	a_p04: assert property (p_p04) else $error("pin input");

	property p_rd_idle;
		!rd_ff |-> (hrdata == 32'h0);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("idle rdata");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------
	c_irq: cover property (do_irq ##[1:20] do_interrupt_return_instruction);
	c_wdt: cover property (wdt_rst);
	c_pin: cover property (pin_reset);
	c_save: cover property (cmd[cmd_save] ##[1:20] cmd[cmd_restore]);
	c_ovf: cover property (ovf);
endmodule // reset_irq_vec

// [ret_stack.sv]
// eight-deep return address stack, registered top of stack
// assumes push and pop never both high
`timescale 1ns/10ps
module ret_stack import vec_pkg::*; #(
	parameter int depth = stack_depth,
	parameter int width = pc_w
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	// stack access
	input wire logic push,
	input wire logic pop,
	input wire logic [width-1:0] wdata,
	output logic [width-1:0] top_ff,
	output logic [3:0] count_ff,
	output logic overflow,
	output logic underflow
);
	logic [width-1:0] mem_ff [depth];
	logic [3:0] ptr_ff;
	wire logic full = (ptr_ff == 4'(depth));
	wire logic empty = (ptr_ff == 4'h0);
	assign overflow = push && full;
	assign underflow = pop && empty;
	assign count_ff = ptr_ff;

	always_ff @(posedge hclk) begin
		// deeper pushes are dropped; oldest entries kept
		if (push && !full)
			mem_ff[ptr_ff[2:0]] <= wdata;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_ff <= 4'h0;
			top_ff <= '0;
		end else if (clear) begin
			ptr_ff <= 4'h0;
			top_ff <= '0;
		end else if (pop && !empty) begin
			ptr_ff <= ptr_ff - 4'h1;
			top_ff <= mem_ff[3'(ptr_ff - 4'h1)];
		end else if (push && !full) begin
			ptr_ff <= ptr_ff + 4'h1;
		end
	end
endmodule // ret_stack

// [vec_partner.sv]
// far-side model: watchdog overflow source and external reset pin
// assumes the bench asks for events through kick and pull_low
`timescale 1ns/10ps
module vec_partner (
	// clock
	input wire logic hclk,
	// requests from the bench
	input wire logic kick,
	input wire logic pull_low,
	// lines into the unit
	output logic wdt_overflow,
	output logic reset_pin
);
	logic pulse = 1'b0;
	// overflow is a one-cycle pulse launched just after an edge
	always @(posedge hclk) begin
		pulse <= kick;
	end
	assign wdt_overflow = pulse;
	// pull-up on the pin: released means high, low only when driven
	assign reset_pin = ~pull_low;
endmodule // vec_partner

// [vec_pkg.sv]
// constants shared by the reset and interrupt vectoring unit
// assumes one 10 MHz core clock and an AHB-Lite register port
package vec_pkg;
	localparam int pc_w = 14;
	localparam int stack_depth = 8;
	localparam logic [13:0] reset_vector = 14'h0000;
	localparam logic [13:0] irq_vector = 14'h0008;
	// register byte offsets
	localparam logic [7:0] off_ctrl = 8'h00;
	localparam logic [7:0] off_pc = 8'h04;
	localparam logic [7:0] off_flag = 8'h08;
	localparam logic [7:0] off_acc = 8'h0c;
	localparam logic [7:0] off_status = 8'h10;
	localparam logic [7:0] off_mask = 8'h14;
	localparam logic [7:0] off_depth = 8'h18;
	// program flag register fields
	localparam int flag_to_bit = 7;
	localparam int flag_pd_bit = 6;
	localparam logic [7:0] cause_mask = 8'hc0;
	// ctrl register command bits (write one to act)
	localparam int cmd_irq = 0;
	localparam int cmd_interrupt_return_instruction = 1;
	localparam int cmd_save = 2;
	localparam int cmd_restore = 3;
	localparam int cmd_wdt = 4;
	localparam int cmd_step = 5;
	// status event bits
	localparam int ev_w = 5;
	localparam int ev_reset = 0;
	localparam int ev_irq = 1;
	localparam int ev_ovf = 2;
	localparam int ev_unf = 3;
	localparam int ev_wake = 4;
	localparam logic [7:0] flag_reset_val = 8'h00;
	localparam logic [7:0] acc_reset_val = 8'h00;
endpackage
